// *** rtl/sbrg_top.v ***
// Baud-rate generator: prescaler, fractional divider and reload timer,
// with its control registers on an AXI4-Lite slave.
// Assumes one clock for bus and generator; the serial channel samples
// baud_pulse on the same clock.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "sbrg_defines.vh"

// Behaviour
// - Baud clock from prescaler, optional fractional divider
// - Timer counts down; tick source set by enable
// - Run bit starts and stops the timer
// - Underflow reloads timer and emits one pulse
// - Normal divider mode stops timer, ignores run
// - Prescaler divides by two to prescale_select
// - Fractional divider scales by step over 256
module sbrg_top
#(
    parameter PRE_W  = 3,
    parameter CNT_W  = 8,
    parameter STEP_W = 8
)
(
    input  wire                    clk,
    input  wire                    rst_b,
    input  wire [`SBRG_ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]              s_axi_awprot,
    input  wire                    s_axi_awvalid,
    output wire                    s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output wire                    s_axi_wready,
    output reg  [1:0]              s_axi_bresp,
    output reg                     s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [`SBRG_ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]              s_axi_arprot,
    input  wire                    s_axi_arvalid,
    output wire                    s_axi_arready,
    output reg  [31:0]             s_axi_rdata,
    output reg  [1:0]              s_axi_rresp,
    output reg                     s_axi_rvalid,
    input  wire                    s_axi_rready,
    output reg                     baud_pulse_q,
    output wire                    norm_div_tick
);

    localparam PDIV_W = (1 << PRE_W) - 1;

    // Mask of low prescaler bits that must be all ones for one tick
    function [PDIV_W-1:0] sbrg_pre_mask;
        input [PRE_W-1:0] sel;
        integer i;
        begin
            sbrg_pre_mask = {PDIV_W{1'b0}};
            for (i = 0; i < PDIV_W; i = i + 1)
            begin
                if (i < sel)
                begin
                    sbrg_pre_mask[i] = 1'b1;
                end
            end
        end
    endfunction

    // Register file
    reg                    baud_run_q;
    reg  [PRE_W-1:0]       prescale_select_q;
    reg  [CNT_W-1:0]       baud_reload_value_q;
    reg                    frac_div_enable_q;
    reg                    frac_div_mode_select_q;
    reg  [STEP_W-1:0]      frac_step_value_q;

    // Bus slave state
    reg                    aw_held_q;
    reg  [`SBRG_ADDR_W-1:0] aw_addr_q;
    reg                    w_held_q;
    reg  [31:0]            w_data_q;
    reg  [3:0]             w_strb_q;
    wire                   do_write;
    wire                   ar_take;
    reg                    wr_hit;
    reg  [31:0]            rd_word;
    reg                    rd_hit;

    // Generator state
    reg  [PDIV_W-1:0]      pre_cnt_q;
    wire [PDIV_W-1:0]      pre_mask;
    wire                   div_tick;
    wire                   frac_tick;
    wire                   tmr_tick;
    wire                   run_eff;
    reg                    running_q;
    reg  [CNT_W-1:0]       reload_count_q;
    reg  [CNT_W-1:0]       reload_count_d;
    reg                    pulse_d;

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign do_write      = aw_held_q && w_held_q;
    // Read channel: one read outstanding
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_take       = s_axi_arvalid && s_axi_arready;

    always @*
    begin
        case (aw_addr_q)
            `SBRG_OFF_CTRL:   wr_hit = 1'b1;
            `SBRG_OFF_RELOAD: wr_hit = 1'b1;
            `SBRG_OFF_FDCTRL: wr_hit = 1'b1;
            `SBRG_OFF_STEP:   wr_hit = 1'b1;
            `SBRG_OFF_STATUS: wr_hit = 1'b1;
            default:          wr_hit = 1'b0;
        endcase
    end

    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `SBRG_OFF_CTRL:
            begin
                rd_word[`SBRG_CTRL_RUN] = baud_run_q;
                rd_word[`SBRG_CTRL_PRE_HI:`SBRG_CTRL_PRE_LO] = prescale_select_q;
            end
            `SBRG_OFF_RELOAD:
            begin
                rd_word[CNT_W-1:0] = baud_reload_value_q;
            end
            `SBRG_OFF_FDCTRL:
            begin
                rd_word[`SBRG_FD_EN]   = frac_div_enable_q;
                rd_word[`SBRG_FD_MODE] = frac_div_mode_select_q;
            end
            `SBRG_OFF_STEP:
            begin
                rd_word[STEP_W-1:0] = frac_step_value_q;
            end
            `SBRG_OFF_STATUS:
            begin
                rd_word[`SBRG_ST_CNT_HI:`SBRG_ST_CNT_LO] = reload_count_q;
                rd_word[`SBRG_ST_RUNNING] = running_q;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_held_q    <= 1'b0;
            aw_addr_q    <= {`SBRG_ADDR_W{1'b0}};
            w_held_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SBRG_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `SBRG_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `SBRG_RESP_OKAY : `SBRG_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `SBRG_RESP_OKAY : `SBRG_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control registers, low byte lane only; status is read-only
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            baud_run_q             <= `SBRG_RST_RUN;
            prescale_select_q      <= `SBRG_RST_PRE;
            baud_reload_value_q    <= `SBRG_RST_RELOAD;
            frac_div_enable_q      <= `SBRG_RST_FD_EN;
            frac_div_mode_select_q <= `SBRG_RST_FD_MODE;
            frac_step_value_q      <= `SBRG_RST_STEP;
        end
        else if (do_write && w_strb_q[0])
        begin
            case (aw_addr_q)
                `SBRG_OFF_CTRL:
                begin
                    baud_run_q        <= w_data_q[`SBRG_CTRL_RUN];
                    prescale_select_q <= w_data_q[`SBRG_CTRL_PRE_HI:`SBRG_CTRL_PRE_LO];
                end
                `SBRG_OFF_RELOAD:
                begin
                    baud_reload_value_q <= w_data_q[CNT_W-1:0];
                end
                `SBRG_OFF_FDCTRL:
                begin
                    frac_div_enable_q      <= w_data_q[`SBRG_FD_EN];
                    frac_div_mode_select_q <= w_data_q[`SBRG_FD_MODE];
                end
                `SBRG_OFF_STEP:
                begin
                    frac_step_value_q <= w_data_q[STEP_W-1:0];
                end
                default:
                begin
                    baud_run_q <= baud_run_q;
                end
            endcase
        end
    end

    // Prescaler: one tick every 2^prescale_select cycles
    assign pre_mask = sbrg_pre_mask(prescale_select_q);
    assign div_tick = (pre_cnt_q & pre_mask) == pre_mask;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_cnt_q <= {PDIV_W{1'b0}};
        end
        else
        begin
            pre_cnt_q <= pre_cnt_q + {{(PDIV_W-1){1'b0}}, 1'b1};
        end
    end

    sbrg_frac_div
    #(
        .STEP_W (STEP_W)
    )
    u_frac_div
    (
        .clk         (clk),
        .rst_b       (rst_b),
        .in_tick     (div_tick),
        .enable      (frac_div_enable_q),
        .mode_select (frac_div_mode_select_q),
        .step        (frac_step_value_q),
        .frac_tick_q (frac_tick),
        .norm_tick_q (norm_div_tick)
    );

    // Timer clock source and run gating
    assign tmr_tick = frac_div_enable_q ? frac_tick : div_tick;
    assign run_eff  = baud_run_q && !(frac_div_enable_q && frac_div_mode_select_q);

    always @*
    begin
        reload_count_d = reload_count_q;
        pulse_d        = 1'b0;
        if (run_eff && !running_q)
        begin
            reload_count_d = baud_reload_value_q;
        end
        else if (run_eff && tmr_tick)
        begin
            if (reload_count_q == {CNT_W{1'b0}})
            begin
                reload_count_d = baud_reload_value_q;
                pulse_d        = 1'b1;
            end
            else
            begin
                reload_count_d = reload_count_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            running_q      <= 1'b0;
            reload_count_q <= {CNT_W{1'b0}};
            baud_pulse_q   <= 1'b0;
        end
        else
        begin
            running_q      <= run_eff;
            reload_count_q <= reload_count_d;
            baud_pulse_q   <= pulse_d;
        end
    end

endmodule // sbrg_top

// *** rtl/sbrg_defines.vh ***
// Register map, field positions and reset values of the baud-rate generator.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef SBRG_DEFINES_VH
`define SBRG_DEFINES_VH

`define SBRG_ADDR_W        5
`define SBRG_OFF_CTRL      5'h00
`define SBRG_OFF_RELOAD    5'h04
`define SBRG_OFF_FDCTRL    5'h08
`define SBRG_OFF_STEP      5'h0c
`define SBRG_OFF_STATUS    5'h10

`define SBRG_CTRL_RUN      0
`define SBRG_CTRL_PRE_LO   1
`define SBRG_CTRL_PRE_HI   3
`define SBRG_FD_EN         0
`define SBRG_FD_MODE       1
`define SBRG_ST_CNT_LO     0
`define SBRG_ST_CNT_HI     7
`define SBRG_ST_RUNNING    8

`define SBRG_RST_RUN       1'h0
`define SBRG_RST_PRE       3'h0
`define SBRG_RST_RELOAD    8'h00
`define SBRG_RST_FD_EN     1'h0
`define SBRG_RST_FD_MODE   1'h0
`define SBRG_RST_STEP      8'h00

`define SBRG_RESP_OKAY     2'h0
`define SBRG_RESP_SLVERR   2'h2

`endif

// *** rtl/sbrg_frac_div.v ***
// Fractional divider of the baud-rate generator.
// Assumes a single clock; in_tick is a one-cycle pulse on that clock.
`timescale 1ns/100ps

module sbrg_frac_div
#(
    parameter STEP_W = 8
)
(
    input  wire              clk,
    input  wire              rst_b,
    input  wire              in_tick,
    input  wire              enable,
    input  wire              mode_select,
    input  wire [STEP_W-1:0] step,
    output reg               frac_tick_q,
    output reg               norm_tick_q
);

    reg  [STEP_W-1:0] acc_q;
    reg  [STEP_W-1:0] acc_d;
    wire [STEP_W:0]   sum;
    wire              norm_wrap;

    // Fractional mode: carry of acc + step yields step/256 of the input ticks
    assign sum       = {1'b0, acc_q} + {1'b0, step};
    // Normal mode: count up from step, wrap at all-ones
    assign norm_wrap = &acc_q;

    always @*
    begin
        acc_d = acc_q;
        if (!enable)
        begin
            acc_d = {STEP_W{1'b0}};
        end
        else if (in_tick && !mode_select)
        begin
            acc_d = sum[STEP_W-1:0];
        end
        else if (in_tick && mode_select)
        begin
            acc_d = norm_wrap ? step : acc_q + {{(STEP_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_q       <= {STEP_W{1'b0}};
            frac_tick_q <= 1'b0;
            norm_tick_q <= 1'b0;
        end
        else
        begin
            acc_q       <= acc_d;
            frac_tick_q <= enable && !mode_select && in_tick && sum[STEP_W];
            norm_tick_q <= enable && mode_select && in_tick && norm_wrap;
        end
    end

endmodule // sbrg_frac_div

// *** verification/sbrg_props.sv ***
// Concurrent checks on the baud-rate generator ports.
// Assumes the bench offers write address and write data in the same cycle.
`timescale 1ns/100ps
`include "sbrg_defines.vh"

module sbrg_props
(
    input wire                    clk,
    input wire                    rst_b,
    input wire [`SBRG_ADDR_W-1:0] s_axi_awaddr,
    input wire                    s_axi_awvalid,
    input wire                    s_axi_awready,
    input wire [31:0]             s_axi_wdata,
    input wire [3:0]              s_axi_wstrb,
    input wire                    s_axi_wvalid,
    input wire                    s_axi_wready,
    input wire                    baud_pulse_q
);
    // Shadow of the generator settings, updated at the write handshake
    logic        run_s;
    logic        fd_en_s;
    logic        fd_mode_s;
    logic        cfg_ok_q;
    logic        start_q;
    logic [2:0]  pre_s;
    logic [7:0]  reload_s;
    logic [7:0]  step_s;
    logic [15:0] gap_q;
    logic [15:0] idle_q;
    logic [15:0] since_q;
    logic [3:0]  age_q;
    wire         wr;
    wire         halt;

    assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    assign halt = !run_s || (fd_en_s && (fd_mode_s || step_s == 8'h00));

    always @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            {run_s, pre_s, reload_s, fd_en_s, fd_mode_s, step_s} <= 22'h0;
            {cfg_ok_q, start_q, gap_q, idle_q, since_q, age_q} <= 54'h0;
        end
        else
        begin
            gap_q <= baud_pulse_q ? 16'h0001 : gap_q + (gap_q != 16'hffff);
            idle_q <= halt ? idle_q + (idle_q != 16'hffff) : 16'h0000;
            since_q <= since_q + 16'h0001;
            age_q <= wr ? 4'h0 : age_q + (age_q != 4'hf);
            if (baud_pulse_q)
            begin
                cfg_ok_q <= age_q > 4'h3;
                start_q <= 1'b0;
            end
            if (wr)
            begin
                cfg_ok_q <= 1'b0;
                start_q <= 1'b0;
                case (s_axi_awaddr)
                    `SBRG_OFF_CTRL:
                    begin
                        run_s <= s_axi_wdata[0];
                        pre_s <= s_axi_wdata[3:1];
                        start_q <= s_axi_wdata[0] && !run_s && s_axi_wdata[3:1] == 3'h0 && !fd_en_s;
                        since_q <= 16'h0000;
                    end
                    `SBRG_OFF_RELOAD: reload_s <= s_axi_wdata[7:0];
                    `SBRG_OFF_FDCTRL: {fd_mode_s, fd_en_s} <= s_axi_wdata[1:0];
                    `SBRG_OFF_STEP: step_s <= s_axi_wdata[7:0];
                    default: ;
                endcase
            end
        end

    pulse_one_a: assert property (@(posedge clk) disable iff (!rst_b)
        baud_pulse_q && cfg_ok_q && (pre_s != 3'h0 || reload_s != 8'h00) |=> !baud_pulse_q)
        else $error("baud pulse wider than one cycle");
    period_a: assert property (@(posedge clk) disable iff (!rst_b)
        baud_pulse_q && cfg_ok_q && run_s && !fd_en_s
        |-> gap_q == ({8'h00, reload_s} + 16'h0001) << pre_s)
        else $error("baud period differs from prescale and reload");
    frac_half_a: assert property (@(posedge clk) disable iff (!rst_b)
        baud_pulse_q && cfg_ok_q && fd_en_s && !fd_mode_s && step_s == 8'h80
        |-> gap_q == (({8'h00, reload_s} + 16'h0001) << pre_s) << 1)
        else $error("half step does not double the period");
    div_one_a: assert property (@(posedge clk) disable iff (!rst_b)
        baud_pulse_q && cfg_ok_q && run_s && !fd_en_s && pre_s == 3'h0 && reload_s == 8'h00
        |=> baud_pulse_q [*2])
        else $error("undivided clock gives no pulse every cycle");
    run_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
        idle_q > 16'h0003 && !run_s |-> !baud_pulse_q)
        else $error("pulse while run bit clear");
    norm_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
        idle_q > 16'h0003 && fd_en_s && fd_mode_s |-> !baud_pulse_q)
        else $error("pulse in normal divider mode");
    zero_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        idle_q > 16'h0003 && fd_en_s && !fd_mode_s && step_s == 8'h00 |-> !baud_pulse_q)
        else $error("pulse with zero fractional step");
    start_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        baud_pulse_q && start_q |-> since_q == {8'h00, reload_s} + 16'h0003)
        else $error("first pulse after start not from reload value");
endmodule // sbrg_props

bind sbrg_top sbrg_props sbrg_props_inst
(
    .clk           (clk),
    .rst_b         (rst_b),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .baud_pulse_q  (baud_pulse_q)
);

// *** verification/sbrg_serial_chan.sv ***
// Serial channel model: counts baud pulses and the cycles between them.
// Assumes baud pulses are sampled on the generator clock.
`timescale 1ns/100ps

module sbrg_serial_chan
(
    input  wire        clk,
    input  wire        rst_b,
    input  wire        baud_pulse_q,
    output reg  [15:0] pulse_cnt_q,
    output reg  [15:0] last_gap_q
);
    reg [15:0] gap_q;

    always @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            pulse_cnt_q <= 16'h0000;
            last_gap_q <= 16'h0000;
            gap_q <= 16'h0000;
        end
        else if (baud_pulse_q)
        begin
            pulse_cnt_q <= pulse_cnt_q + 16'h0001;
            last_gap_q <= gap_q + 16'h0001;
            gap_q <= 16'h0000;
        end
        else
            gap_q <= gap_q + 16'h0001;
endmodule // sbrg_serial_chan

// *** verification/testbench.sv ***
// Self-checking bench for the baud-rate generator over AXI4-Lite.
// Assumes one 20 MHz clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`include "sbrg_defines.vh"

module testbench;
    logic                    clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic [`SBRG_ADDR_W-1:0] awaddr, araddr;
    logic [31:0]             wdata, rd;
    logic [3:0]              wstrb;
    logic [1:0]              rp;
    logic [51:0]             r;
    logic [15:0]             c;
    wire                     awready, wready, bvalid, arready, rvalid, pulse, ntick;
    wire [1:0]               bresp, rresp;
    wire [31:0]              rdata;
    wire [15:0]              pcnt, gap;
    int                      num_errors, comparisons, nt;
    // run, select, reload, enable, mode, step, expected pulse period
    logic [51:0] tbl [9] = '{52'h1_0_00_0_0_00_0001, 52'h1_0_01_0_0_00_0002,
        52'h1_2_03_0_0_00_0010, 52'h1_7_02_0_0_00_0180, 52'h1_1_ff_0_0_00_0200,
        52'h1_0_01_1_0_80_0004, 52'h1_0_01_1_1_80_0000, 52'h1_0_01_1_0_00_0000,
        52'h0_0_01_0_0_00_0000};

    sbrg_top sbrg_top_inst (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .baud_pulse_q(pulse), .norm_div_tick(ntick));
    sbrg_serial_chan sbrg_serial_chan_inst (.clk(clk), .rst_b(rst_b),
        .baud_pulse_q(pulse), .pulse_cnt_q(pcnt), .last_gap_q(gap));

    task results;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chkr(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask

    // One AXI4-Lite transfer; holds each valid until its ready is sampled
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw, tr, tb;
        @(posedge clk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge clk);
            ta = awready;
            tw = wready;
            tr = arready;
            tb = wr ? bvalid : rvalid;
            rp = wr ? bresp : rresp;
            rd = rdata;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
        end
        bready <= 1'b0;
        rready <= 1'b0;
    endtask

    task pulses(input int n);
        int k;
        c = pcnt;
        k = 0;
        while (pcnt - c < n && k < 4000)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 4000)
        begin
            num_errors++;
            $display("MISMATCH at %0t: no baud pulse", $time);
        end
    endtask

    task regs_zero;
        for (int a = 0; a < 5; a++)
        begin
            bus(1'b0, {a[2:0], 2'b00}, 32'h0, 4'h0);
            chk(rd, 32'h0);
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        results();
    end

    initial
    begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = 46'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        regs_zero();
        for (int i = 0; i < 9; i++)
        begin
            r = tbl[i];
            bus(1'b1, `SBRG_OFF_FDCTRL, {30'h0, r[24], r[28]}, 4'hf);
            bus(1'b1, `SBRG_OFF_STEP, {24'h0, r[23:16]}, 4'hf);
            bus(1'b1, `SBRG_OFF_RELOAD, {24'h0, r[39:32]}, 4'hf);
            bus(1'b1, `SBRG_OFF_CTRL, {28'h0, r[42:40], r[44]}, 4'hf);
            bus(1'b0, `SBRG_OFF_CTRL, 32'h0, 4'h0);
            chk(rd, {28'h0, r[42:40], r[44]});
            bus(1'b0, `SBRG_OFF_STATUS, 32'h0, 4'h0);
            chk({31'h0, rd[8]}, {31'h0, r[44] && !(r[28] && r[24])});
            if (r[15:0] != 16'h0000)
            begin
                pulses(3);
                chk({16'h0, gap}, {16'h0, r[15:0]});
            end
            else
            begin
                repeat (20) @(negedge clk);
                pulses(0);
                nt = 0;
                // Normal divider ticks every 128 cycles; count over a settled 512-cycle window
                for (int k = 0; k < 752; k++)
                begin
                    @(negedge clk);
                    if (k >= 240 && ntick)
                        nt++;
                end
                chk({16'h0, pcnt}, {16'h0, c});
                chk(nt, (r[28] && r[24]) ? 32'h0000_0004 : 32'h0000_0000);
            end
        end
        // Restart from stop with a new reload value
        bus(1'b1, `SBRG_OFF_RELOAD, 32'h0000_0005, 4'hf);
        bus(1'b1, `SBRG_OFF_CTRL, 32'h0000_0001, 4'hf);
        pulses(3);
        chk({16'h0, gap}, 32'h0000_0006);
        // Unmapped place, read-only status, masked write
        bus(1'b1, 5'h14, 32'h0000_00ff, 4'hf);
        chkr(rp, `SBRG_RESP_SLVERR);
        bus(1'b0, 5'h14, 32'h0, 4'h0);
        chkr(rp, `SBRG_RESP_SLVERR);
        chk(rd, 32'h0);
        bus(1'b1, `SBRG_OFF_STATUS, 32'hffff_ffff, 4'hf);
        chkr(rp, `SBRG_RESP_OKAY);
        bus(1'b1, `SBRG_OFF_RELOAD, 32'h0000_0055, 4'h0);
        chkr(rp, `SBRG_RESP_OKAY);
        bus(1'b0, `SBRG_OFF_RELOAD, 32'h0, 4'h0);
        chk(rd, 32'h0000_0005);
        // Reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (100) @(negedge clk);
        chk({16'h0, pcnt}, 32'h0);
        regs_zero();
        results();
    end
endmodule // testbench
